// ### rtl/ptw_pkg.sv
// Shared constants and carrier types for the transmit packet write port
package ptw_pkg;
  localparam int DATA_W = 32;
  localparam int MOD_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int LINK_CLK_MHZ = 100;
  localparam int CORE_CLK_MHZ = 20;
  localparam logic [1:0] MOD_ALL = 2'h0;
  localparam logic [1:0] MOD_THREE = 2'h1;
  localparam logic [1:0] MOD_TWO = 2'h2;
  localparam logic [1:0] MOD_ONE = 2'h3;
  localparam logic [3:0] LANES_ALL = 4'hf;
  localparam logic [3:0] LANES_THREE = 4'he;
  localparam logic [3:0] LANES_TWO = 4'hc;
  localparam logic [3:0] LANES_ONE = 4'h8;
  localparam logic [3:0] FREE_MIN_DEFAULT = 4'h2;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic [3:0] PTR_RST = 4'h0;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] lanes;
    logic sop;
    logic eop;
    logic abort;
    logic parityErr;
  } ptw_word_t;

  typedef enum logic [1:0] {
    PTW_IDLE = 2'b00,
    PTW_PKT = 2'b01,
    PTW_DROP = 2'b11
  } ptw_state_t;
endpackage : ptw_pkg

// ### rtl/ptw_port.sv
// Transmit packet write port with dual-clock word FIFO
`timescale 1ns/1ns

module ptw_port #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic linkClk,
  input wire logic linkRst,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  output logic [AW:0] wrFree,
  input wire logic clk,
  input wire logic srst,
  output logic [WIDTH-1:0] rdData,
  output logic rdValid,
  input wire logic rdReady
);
  // Gray pointers cross domains; one spare bit tells full from empty
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wBin_r, wBin_nxt, wGray_r, wGray_nxt;
  logic [AW:0] rBin_r, rBin_nxt, rGray_r, rGray_nxt;
  logic [AW:0] rGrayS1_r, rGrayS2_r, wGrayS1_r, wGrayS2_r;
  logic [AW:0] rBinInW, wBinInR;
  logic doWrite, doRead;

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : gray2bin

  always_comb
  begin
    rBinInW = gray2bin(rGrayS2_r);
    wBinInR = gray2bin(wGrayS2_r);
    wrFree = (AW + 1)'(DEPTH) - (wBin_r - rBinInW);
    wrReady = (wBin_r - rBinInW) != (AW + 1)'(DEPTH);
    rdValid = wBinInR != rBin_r;
    rdData = mem[rBin_r[AW-1:0]];
    doWrite = wrValid && wrReady;
    doRead = rdValid && rdReady;
    wBin_nxt = wBin_r + (AW + 1)'(doWrite);
    rBin_nxt = rBin_r + (AW + 1)'(doRead);
    wGray_nxt = wBin_nxt ^ (wBin_nxt >> 1);
    rGray_nxt = rBin_nxt ^ (rBin_nxt >> 1);
  end

  always_ff @(posedge linkClk)
  begin
    if (doWrite)
      mem[wBin_r[AW-1:0]] <= wrData;
    if (linkRst)
    begin
      wBin_r <= '0;
      wGray_r <= '0;
      rGrayS1_r <= '0;
      rGrayS2_r <= '0;
    end
    else
    begin
      wBin_r <= wBin_nxt;
      wGray_r <= wGray_nxt;
      rGrayS1_r <= rGray_r;
      rGrayS2_r <= rGrayS1_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rBin_r <= '0;
      rGray_r <= '0;
      wGrayS1_r <= '0;
      wGrayS2_r <= '0;
    end
    else
    begin
      rBin_r <= rBin_nxt;
      rGray_r <= rGray_nxt;
      wGrayS1_r <= wGray_r;
      wGrayS2_r <= wGrayS1_r;
    end
  end
endmodule : ptw_port

module ptw_tx_write #(
  parameter int DEPTH = ptw_pkg::FIFO_DEPTH,
  parameter logic [3:0] FREE_MIN = ptw_pkg::FREE_MIN_DEFAULT
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic txClk,
  input wire logic txRst,
  input wire logic txEnableN,
  input wire logic [31:0] txData,
  input wire logic [1:0] txMod,
  input wire logic txSop,
  input wire logic txEop,
  input wire logic txErr,
  input wire logic txParity,
  input wire logic parity_check_disable,
  output logic txPktAvail,
  output logic [31:0] outData,
  output logic [3:0] outLanes,
  output logic outSop,
  output logic outEop,
  output logic outAbort,
  output logic outParityErr,
  output logic outValid,
  input wire logic outReady,
  input wire logic parityErrClear,
  output logic parityErrSticky
);
  localparam int WW = $bits(ptw_pkg::ptw_word_t);
  localparam int AW = $clog2(DEPTH);

  // Link domain: register the bus pins once on the rising edge
  ptw_pkg::ptw_word_t inWord_r, inWord_nxt;
  logic inValid_r, inValid_nxt;
  logic disSync1_r, disSync2_r;
  ptw_pkg::ptw_state_t state_r, state_nxt;
  logic avail_r, avail_nxt;
  logic pushValid, pushReady;
  logic [AW:0] freeWords;
  logic [3:0] lanes;
  logic parityBad;
  logic [WW-1:0] popBits;
  ptw_pkg::ptw_word_t popWord;
  logic popValid;
  logic clrSync1_r, clrSync2_r;
  logic sticky_r, sticky_nxt;
  logic [1:0] errTog_r, errTog_nxt;
  logic errTogS1_r, errTogS2_r, errTogS3_r;

  always_comb
  begin
    unique case (txMod)
      ptw_pkg::MOD_ALL: lanes = ptw_pkg::LANES_ALL;
      ptw_pkg::MOD_THREE: lanes = ptw_pkg::LANES_THREE;
      ptw_pkg::MOD_TWO: lanes = ptw_pkg::LANES_TWO;
      ptw_pkg::MOD_ONE: lanes = ptw_pkg::LANES_ONE;
    endcase
    // Modulo only counts on the last word; elsewhere treat the word as full
    if (!txEop)
      lanes = ptw_pkg::LANES_ALL;
    parityBad = !disSync2_r && ((^txData) ^ txParity) != 1'b1;
    inWord_nxt.data = txData;
    inWord_nxt.lanes = lanes;
    inWord_nxt.sop = txSop;
    inWord_nxt.eop = txEop;
    inWord_nxt.abort = txErr && txEop;
    inWord_nxt.parityErr = parityBad;
    inValid_nxt = !txEnableN;
  end

  // Packet tracking; words of a packet that found the FIFO full are dropped until end
  always_comb
  begin
    state_nxt = state_r;
    pushValid = 1'b0;
    errTog_nxt = errTog_r;
    if (inValid_r)
    begin
      if (inWord_r.parityErr)
        errTog_nxt = errTog_r + 2'h1;
      unique case (state_r)
        ptw_pkg::PTW_IDLE,
        ptw_pkg::PTW_PKT:
        begin
          if (state_r == ptw_pkg::PTW_PKT || inWord_r.sop)
          begin
            pushValid = 1'b1;
            if (!pushReady)
              state_nxt = inWord_r.eop ? ptw_pkg::PTW_IDLE : ptw_pkg::PTW_DROP;
            else
              state_nxt = inWord_r.eop ? ptw_pkg::PTW_IDLE : ptw_pkg::PTW_PKT;
          end
        end
        ptw_pkg::PTW_DROP:
        begin
          if (inWord_r.eop)
            state_nxt = ptw_pkg::PTW_IDLE;
        end
        default: state_nxt = ptw_pkg::PTW_IDLE;
      endcase
    end
    avail_nxt = freeWords > (AW + 1)'(FREE_MIN);
  end

  always_ff @(posedge txClk)
  begin
    if (txRst)
    begin
      inWord_r <= '0;
      inValid_r <= 1'b0;
      disSync1_r <= 1'b0;
      disSync2_r <= 1'b0;
      state_r <= ptw_pkg::PTW_IDLE;
      avail_r <= 1'b0;
      errTog_r <= ptw_pkg::SYNC_RST;
    end
    else
    begin
      inWord_r <= inWord_nxt;
      inValid_r <= inValid_nxt;
      disSync1_r <= parity_check_disable;
      disSync2_r <= disSync1_r;
      state_r <= state_nxt;
      avail_r <= avail_nxt;
      errTog_r <= errTog_nxt;
    end
  end

  assign txPktAvail = avail_r;

  // single port: no address or start-of-transfer inputs exist
  ptw_port #(
    .WIDTH(WW),
    .DEPTH(DEPTH),
    .AW(AW)
  ) fifo (
    .linkClk(txClk),
    .linkRst(txRst),
    .wrData(inWord_r),
    .wrValid(pushValid),
    .wrReady(pushReady),
    .wrFree(freeWords),
    .clk(clk),
    .srst(srst),
    .rdData(popBits),
    .rdValid(popValid),
    .rdReady(outReady && outValid || !outValid)
  );

  assign popWord = ptw_pkg::ptw_word_t'(popBits);

  // Core-side output stage keeps every output on a flip-flop
  ptw_pkg::ptw_word_t outWord_r, outWord_nxt;
  logic outValid_r, outValid_nxt;

  always_comb
  begin
    outWord_nxt = outWord_r;
    outValid_nxt = outValid_r;
    if (outReady || !outValid_r)
    begin
      outValid_nxt = popValid;
      if (popValid)
        outWord_nxt = popWord;
    end
    // Any toggle step is a new parity event; set wins over clear
    sticky_nxt = sticky_r;
    if (clrSync2_r)
      sticky_nxt = 1'b0;
    if (errTogS3_r != errTogS2_r)
      sticky_nxt = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      outWord_r <= '0;
      outValid_r <= 1'b0;
      sticky_r <= 1'b0;
      clrSync1_r <= 1'b0;
      clrSync2_r <= 1'b0;
      errTogS1_r <= 1'b0;
      errTogS2_r <= 1'b0;
      errTogS3_r <= 1'b0;
    end
    else
    begin
      outWord_r <= outWord_nxt;
      outValid_r <= outValid_nxt;
      sticky_r <= sticky_nxt;
      clrSync1_r <= parityErrClear;
      clrSync2_r <= clrSync1_r;
      errTogS1_r <= errTog_r[0];
      errTogS2_r <= errTogS1_r;
      errTogS3_r <= errTogS2_r;
    end
  end

  assign outData = outWord_r.data;
  assign outLanes = outWord_r.lanes;
  assign outSop = outWord_r.sop;
  assign outEop = outWord_r.eop;
  assign outAbort = outWord_r.abort;
  assign outParityErr = outWord_r.parityErr;
  assign outValid = outValid_r;
  assign parityErrSticky = sticky_r;
endmodule : ptw_tx_write

// ### tb/ptw_tx_write_checker.sv
// Port assertions for the transmit write port
`timescale 1ns/1ns
module ptw_tx_write_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic [31:0] outData,
  input wire logic [3:0] outLanes,
  input wire logic outSop,
  input wire logic outEop,
  input wire logic outAbort,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic parityErrClear,
  input wire logic parityErrSticky
);
  logic open_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  always_ff @(posedge clk)
    if (srst)
      open_r <= 1'b0;
    else if (outValid && outReady)
      open_r <= !outEop;
  property p_mid;
    outValid && !outEop |-> outLanes == 4'hf;
  endproperty
  a_mid: assert property (p_mid) else $error("mid lanes");
  property p_end;
    outValid && outEop |-> outLanes inside {4'hf, 4'he, 4'hc, 4'h8};
  endproperty
  a_end: assert property (p_end) else $error("end lanes");
  property p_abt;
    outValid && outAbort |-> outEop;
  endproperty
  a_abt: assert property (p_abt) else $error("abort");
  property p_vh;
    outValid && !outReady |=> outValid;
  endproperty
  a_vh: assert property (p_vh) else $error("valid hold");
  property p_dh;
    outValid && !outReady |=> $stable(outData);
  endproperty
  a_dh: assert property (p_dh) else $error("data hold");
  property p_fh;
    outValid && !outReady |=> $stable({outLanes, outSop, outEop, outAbort});
  endproperty
  a_fh: assert property (p_fh) else $error("flag hold");
  // Words before a start are dropped, so a closed packet must reopen with a start
  property p_sop;
    outValid && !open_r |-> outSop;
  endproperty
  a_sop: assert property (p_sop) else $error("no start");
  property p_stk;
    !parityErrClear [*3] ##0 parityErrSticky |=> parityErrSticky;
  endproperty
  a_stk: assert property (p_stk) else $error("sticky");
endmodule : ptw_tx_write_checker

bind ptw_tx_write ptw_tx_write_checker i_chk (.clk, .srst, .outData, .outLanes, .outSop, .outEop, .outAbort,
  .outValid, .outReady, .parityErrClear, .parityErrSticky);

// ### tb/ptw_writer.sv
// Link-side packet writer model
`timescale 1ns/1ns
module ptw_writer (
  input wire logic txClk,
  output logic txEnableN,
  output logic [31:0] txData,
  output logic [1:0] txMod,
  output logic txSop,
  output logic txEop,
  output logic txErr,
  output logic txParity
);
  initial
  begin
    txEnableN = 1'b1;
    {txData, txMod, txSop, txEop, txErr, txParity} = '0;
  end
  // Flags f: start, end, error, bad parity
  task automatic put(input logic [31:0] d, input logic [1:0] m, input logic [3:0] f);
    @(posedge txClk);
    txEnableN <= 1'b0;
    txData <= d;
    txMod <= f[2] ? m : 2'h0;
    txSop <= f[3];
    txEop <= f[2];
    txErr <= f[1] & f[2];
    txParity <= ~^d ^ f[0];
    @(posedge txClk);
    txEnableN <= 1'b1;
    // Idle bus shows every qualified line inverted so stale values never look valid
    txData <= ~d;
    txMod <= ~txMod;
    txSop <= ~txSop;
    txEop <= ~txEop;
    txErr <= ~txErr;
    txParity <= ~txParity;
  endtask : put
endmodule : ptw_writer

// ### tb/tb_top.sv
// Bench for the transmit write port
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic txClk = 1'b0;
  logic srst = 1'b1;
  logic parity_check_disable = 1'b0;
  logic outReady = 1'b0;
  logic parityErrClear = 1'b0;
  logic txEnableN, txSop, txEop, txErr, txParity, txPktAvail, outSop, outEop, outAbort, outParityErr;
  logic outValid, parityErrSticky;
  logic [31:0] txData, outData;
  logic [1:0] txMod;
  logic [3:0] outLanes;
  // Fields: mod, error, bad parity, disable | lanes, abort, parity error
  logic [11:0] rows [7] = '{12'h03c, 12'h238, 12'h430, 12'h620, 12'h13e, 12'h0bd, 12'h0fc};
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  always
  begin
    #7 txClk = 1'b1;
    #8 txClk = 1'b0;
  end
  ptw_tx_write i_ptw_tx_write (.clk, .srst, .txClk, .txRst(srst), .txEnableN, .txData, .txMod, .txSop, .txEop,
    .txErr, .txParity, .parity_check_disable, .txPktAvail, .outData, .outLanes, .outSop, .outEop, .outAbort,
    .outParityErr, .outValid, .outReady, .parityErrClear, .parityErrSticky);
  ptw_writer i_ptw_writer (.txClk, .txEnableN, .txData, .txMod, .txSop, .txEop, .txErr, .txParity);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Flags f: start, end, abort, parity error
  task automatic pop(input logic [31:0] d, input logic [3:0] l, input logic [3:0] f);
    @(negedge clk);
    for (int i = 0; i < 100 && outValid !== 1'b1; i++)
      @(negedge clk);
    chk("data", d, outData);
    chk("lanes", {28'h0, l}, {28'h0, outLanes});
    chk("flags", {28'h0, f}, {28'h0, outSop, outEop, outAbort, outParityErr});
    @(posedge clk);
    outReady <= 1'b1;
    @(posedge clk);
    outReady <= 1'b0;
  endtask : pop
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("valid", 32'h0, {31'h0, outValid});
    chk("sticky", 32'h0, {31'h0, parityErrSticky});
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++)
    begin
      parity_check_disable <= rows[i][6];
      repeat (3) @(posedge clk);
      i_ptw_writer.put(32'h1a2b3c4d + i, rows[i][10:9], {2'h3, rows[i][8:7]});
      pop(32'h1a2b3c4d + i, rows[i][5:2], {2'h3, rows[i][1:0]});
    end
    chk("sticky", 32'h1, {31'h0, parityErrSticky});
    parityErrClear <= 1'b1;
    repeat (4) @(posedge clk);
    parityErrClear <= 1'b0;
    @(negedge clk);
    chk("cleared", 32'h0, {31'h0, parityErrSticky});
    // An end without a start must vanish, then a two-word packet follows
    i_ptw_writer.put(32'h0, 2'h0, 4'h4);
    i_ptw_writer.put(32'hcafe0001, 2'h0, 4'h8);
    i_ptw_writer.put(32'hcafe0002, 2'h1, 4'h4);
    pop(32'hcafe0001, 4'hf, 4'h8);
    pop(32'hcafe0002, 4'he, 4'h4);
    chk("avail", 32'h1, {31'h0, txPktAvail});
    // Availability is read between link edges, never on the edge that updates it
    i_ptw_writer.put(32'h0, 2'h0, 4'h8);
    @(negedge txClk);
    for (int k = 1; k < 20 && txPktAvail === 1'b1; k++)
    begin
      i_ptw_writer.put(k, 2'h0, 4'h0);
      @(negedge txClk);
    end
    i_ptw_writer.put(32'h0, 2'h1, 4'h4);
    @(negedge txClk);
    chk("full", 32'h0, {31'h0, txPktAvail});
    pop(32'h0, 4'hf, 4'h8);
    @(posedge clk);
    outReady <= 1'b1;
    repeat (60) @(posedge clk);
    outReady <= 1'b0;
    @(negedge clk);
    chk("avail", 32'h1, {31'h0, txPktAvail});
    chk("drained", 32'h0, {31'h0, outValid});
    // Reset in mid-run with a packet open and a parity error latched
    @(posedge clk);
    parity_check_disable <= 1'b0;
    repeat (3) @(posedge clk);
    i_ptw_writer.put(32'h55aa55aa, 2'h0, 4'h9);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("perr", 32'h1, {31'h0, parityErrSticky});
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("rst valid", 32'h0, {31'h0, outValid});
    chk("rst sticky", 32'h0, {31'h0, parityErrSticky});
    repeat (3) @(posedge txClk);
    // The packet cut by reset must not resume: a bare end is dropped
    i_ptw_writer.put(32'h77, 2'h0, 4'h4);
    i_ptw_writer.put(32'h600dc0de, 2'h3, 4'hc);
    pop(32'h600dc0de, 4'h8, 4'hc);
    summarize();
  end
endmodule : tb_top
